/* File: verilog/codec_pin_function_mux.sv */
// What this block does
// - Upper nibble picks pin role; 0000 disables
// - Code 0010 outputs headset interrupt, 1.75 ms
// - 0011 general input, 0100 general output
// - 0101-0111 mic data, both clock edges sampled
// - 1000 pin is serial bit clock
// - 1001 outputs headset OR button interrupt
// - 1010 outputs OR of all four interrupts
// - 1100 outputs headset, button, short OR
// - 1101 and 1110 output short-circuit alone
// - 1111 outputs button or hook-switch interrupt
// - Output-value bit sets pin level
// - Input-value bit shows pin level
// - Duration bit: single pulse or repeat
// - Data-line mode: off, input, output
// - Data line only pulled low, open drain
// - Data-line output bit: low or release
// - Data-line input bit shows line level
// - Clock-line mode same encoding as data line
// - Control-line GPIO only in SPI strap mode
// - Clock-line output and input bits
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
module codec_pin_function_mux #(
   parameter int PULSE_LEN   = codec_pin_pkg::PULSE_CYCLES,
   parameter int HEADSET_LEN = codec_pin_pkg::HEADSET_CYCLES,
   parameter int CNT_W       = 16
) (
   input  wire logic                         clk_sys,
   input  wire logic                         rst,
   // AHB-Lite slave
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic                              hreadyout,
   output logic [31:0]                       hrdata,
   output logic                              hresp,
   // Interrupt sources and acknowledge
   input  wire codec_pin_pkg::irq_source_type irqSource,
   input  wire logic                         flagRead,
   // Microphone and serial bit clock
   input  wire logic                         micClock,
   output logic                              micData,
   output logic                              micDataValid,
   input  wire logic                         bitClockIsOutput,
   input  wire logic                         bitClockOut,
   output logic                              bitClockIn,
   // Control-bus select strap, high for SPI
   input  wire logic                         selectSpi,
   // Second multi-function pin
   input  wire logic                         pinIn,
   output codec_pin_pkg::pin_drive_type      pinDrive,
   // Data and clock lines of the control bus
   input  wire logic                         sdaIn,
   output codec_pin_pkg::pin_drive_type      sdaDrive,
   input  wire logic                         sclIn,
   output codec_pin_pkg::pin_drive_type      sclDrive
);

   // ------------------------------------------------------------
   // Parameter checks
   // ------------------------------------------------------------
   if (PULSE_LEN < 1 || PULSE_LEN >= (1 << CNT_W) ||
       HEADSET_LEN < 1 || HEADSET_LEN >= (1 << CNT_W)) begin : g_bad_len
      $error("Pulse lengths must fit the counter and be at least one");
   end

   localparam logic [CNT_W-1:0] PULSE_LOAD   = CNT_W'(PULSE_LEN - 1);
   localparam logic [CNT_W-1:0] HEADSET_LOAD = CNT_W'(HEADSET_LEN - 1);
   localparam logic [1:0]       TRANS_NONSEQ = 2'h2;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Four pins, two flops each; only stage two is ever read
   logic [3:0] syncFirst;
   logic [3:0] syncSecond;
   logic [3:0] rawPins;
   assign rawPins = {selectSpi, sclIn, sdaIn, pinIn};

   genvar g;
   for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            syncFirst[g]  <= 1'b0;
            syncSecond[g] <= 1'b0;
         end else begin
            syncFirst[g]  <= rawPins[g];
            syncSecond[g] <= syncFirst[g];
         end
      end
   end

   logic pinLevel;
   logic sdaLevel;
   logic sclLevel;
   logic spiMode;
   assign pinLevel = syncSecond[0];
   assign sdaLevel = syncSecond[1];
   assign sclLevel = syncSecond[2];
   assign spiMode  = syncSecond[3];

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] pinFunction;
   logic [7:0] controlPins;
   logic       dataPhaseWrite;
   logic [31:0] dataPhaseAddr;

   codec_pin_pkg::function_type  pinRole;
   codec_pin_pkg::line_mode_type dataMode;
   codec_pin_pkg::line_mode_type clockMode;
   assign pinRole   = codec_pin_pkg::function_type'(
                         pinFunction[codec_pin_pkg::FUNC_HI:
                                     codec_pin_pkg::FUNC_LO]);
   assign dataMode  = codec_pin_pkg::line_mode_type'(
                         controlPins[codec_pin_pkg::DATA_MODE_HI:
                                     codec_pin_pkg::DATA_MODE_LO]);
   assign clockMode = codec_pin_pkg::line_mode_type'(
                         controlPins[codec_pin_pkg::CLK_MODE_HI:
                                     codec_pin_pkg::CLK_MODE_LO]);

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------
   logic addrPhase;
   assign addrPhase = hsel && hready && (htrans == TRANS_NONSEQ);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dataPhaseWrite <= 1'b0;
         dataPhaseAddr  <= 32'h00000000;
      end else begin
         if (hready) begin
            dataPhaseWrite <= addrPhase && hwrite;
            dataPhaseAddr  <= haddr;
         end
      end
   end

   // Zero wait states, always OKAY
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Live bits are merged at read time; reserved bit 0 reads zero
   logic [7:0] pinFunctionView;
   logic [7:0] controlPinsView;
   always_comb begin
      pinFunctionView = pinFunction;
      pinFunctionView[codec_pin_pkg::BIT_IN_VAL] = pinLevel;
      controlPinsView = controlPins;
      controlPinsView[codec_pin_pkg::BIT_DATA_IN] = sdaLevel;
      controlPinsView[codec_pin_pkg::BIT_CLK_IN]  = sclLevel;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h00000000;
      end else begin
         if (addrPhase && !hwrite) begin
            if (haddr == codec_pin_pkg::ADDR_PIN_FUNCTION) begin
               hrdata <= {24'h000000, pinFunctionView};
            end else if (haddr == codec_pin_pkg::ADDR_CONTROL_PINS) begin
               hrdata <= {24'h000000, controlPinsView};
            end else begin
               hrdata <= 32'h00000000;
            end
         end
      end
   end

   // Writes land in the data phase; read-only and reserved bits kept 0
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinFunction <= codec_pin_pkg::RESET_PIN_FUNCTION;
         controlPins <= codec_pin_pkg::RESET_CONTROL_PINS;
      end else begin
         if (dataPhaseWrite &&
             dataPhaseAddr == codec_pin_pkg::ADDR_PIN_FUNCTION) begin
            pinFunction <= {hwdata[7:3], 1'b0, hwdata[1], 1'b0};
         end
         if (dataPhaseWrite &&
             dataPhaseAddr == codec_pin_pkg::ADDR_CONTROL_PINS) begin
            controlPins <= {hwdata[7:5], 1'b0, hwdata[3:1], 1'b0};
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt selection
   // ------------------------------------------------------------
   function automatic logic selectIrq(
      input codec_pin_pkg::function_type   role,
      input codec_pin_pkg::irq_source_type src
   );
      logic hit;
      hit = 1'b0;
      unique case (role)
         codec_pin_pkg::FN_HEADSET:   hit = src.headset;
         codec_pin_pkg::FN_HS_BTN:    hit = src.headset | src.button;
         codec_pin_pkg::FN_ALL_FOUR:  hit = src.headset | src.button |
                                            src.shortCircuit |
                                            src.gainNoise;
         codec_pin_pkg::FN_SC_BTN:    hit = src.shortCircuit |
                                            src.button;
         codec_pin_pkg::FN_HS_BTN_SC: hit = src.headset | src.button |
                                            src.shortCircuit;
         codec_pin_pkg::FN_SC_A,
         codec_pin_pkg::FN_SC_B:      hit = src.shortCircuit;
         codec_pin_pkg::FN_BUTTON:    hit = src.button;
         codec_pin_pkg::FN_DISABLED, codec_pin_pkg::FN_RESERVED,
         codec_pin_pkg::FN_GP_INPUT, codec_pin_pkg::FN_GP_OUTPUT,
         codec_pin_pkg::FN_MIC_A, codec_pin_pkg::FN_MIC_B,
         codec_pin_pkg::FN_MIC_C, codec_pin_pkg::FN_BIT_CLOCK:
                                      hit = 1'b0;
      endcase
      return hit;
   endfunction

   logic irqNow;
   logic irqBefore;
   logic irqRise;
   assign irqNow  = selectIrq(pinRole, irqSource);
   assign irqRise = irqNow && !irqBefore;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irqBefore <= 1'b0;
      end else begin
         irqBefore <= irqNow;
      end
   end

   // ------------------------------------------------------------
   // Pulse generator
   // ------------------------------------------------------------
   // Repeat mode gaps equal the pulse length so the host sees a
   // square wave until it reads the flag register
   codec_pin_pkg::pulse_state_type pulseState;
   logic [CNT_W-1:0] pulseCount;
   logic             repeatPending;
   logic [CNT_W-1:0] loadValue;
   logic             repeatMode;
   assign repeatMode = pinFunction[codec_pin_pkg::BIT_REPEAT];
   assign loadValue  = (pinRole == codec_pin_pkg::FN_HEADSET) ?
                       HEADSET_LOAD : PULSE_LOAD;

   // A new event wins over an acknowledge in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         repeatPending <= 1'b0;
      end else begin
         if (irqRise && repeatMode) begin
            repeatPending <= 1'b1;
         end else if (flagRead || !repeatMode) begin
            repeatPending <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pulseState <= codec_pin_pkg::PULSE_IDLE;
         pulseCount <= '0;
      end else begin
         unique case (pulseState)
            codec_pin_pkg::PULSE_IDLE: begin
               if (irqRise) begin
                  pulseState <= codec_pin_pkg::PULSE_HIGH;
                  pulseCount <= loadValue;
               end
            end
            codec_pin_pkg::PULSE_HIGH: begin
               if (pulseCount != '0) begin
                  pulseCount <= pulseCount - 1'b1;
               end else if (repeatPending && !flagRead) begin
                  pulseState <= codec_pin_pkg::PULSE_GAP;
                  pulseCount <= loadValue;
               end else begin
                  pulseState <= codec_pin_pkg::PULSE_IDLE;
               end
            end
            codec_pin_pkg::PULSE_GAP: begin
               if (!repeatPending) begin
                  pulseState <= codec_pin_pkg::PULSE_IDLE;
               end else if (pulseCount != '0) begin
                  pulseCount <= pulseCount - 1'b1;
               end else begin
                  pulseState <= codec_pin_pkg::PULSE_HIGH;
                  pulseCount <= loadValue;
               end
            end
            default: begin
               pulseState <= codec_pin_pkg::PULSE_IDLE;
            end
         endcase
      end
   end

   logic pulseLevel;
   assign pulseLevel = (pulseState == codec_pin_pkg::PULSE_HIGH);

   // ------------------------------------------------------------
   // Microphone capture and bit clock
   // ------------------------------------------------------------
   logic micClockBefore;
   logic micRole;
   assign micRole = (pinRole == codec_pin_pkg::FN_MIC_A) ||
                    (pinRole == codec_pin_pkg::FN_MIC_B) ||
                    (pinRole == codec_pin_pkg::FN_MIC_C);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         micClockBefore <= 1'b0;
         micData        <= 1'b0;
         micDataValid   <= 1'b0;
      end else begin
         micClockBefore <= micClock;
         micDataValid   <= 1'b0;
         if (micRole && (micClock != micClockBefore)) begin
            micData      <= pinLevel;
            micDataValid <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         bitClockIn <= 1'b0;
      end else begin
         bitClockIn <= (pinRole == codec_pin_pkg::FN_BIT_CLOCK) &&
                       !bitClockIsOutput && pinLevel;
      end
   end

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pinDrive <= '0;
      end else begin
         unique case (pinRole)
            codec_pin_pkg::FN_DISABLED, codec_pin_pkg::FN_RESERVED,
            codec_pin_pkg::FN_GP_INPUT, codec_pin_pkg::FN_MIC_A,
            codec_pin_pkg::FN_MIC_B, codec_pin_pkg::FN_MIC_C: begin
               pinDrive <= '0;
            end
            codec_pin_pkg::FN_GP_OUTPUT: begin
               pinDrive.level  <= pinFunction[codec_pin_pkg::BIT_OUT_VAL];
               pinDrive.enable <= 1'b1;
            end
            codec_pin_pkg::FN_BIT_CLOCK: begin
               pinDrive.level  <= bitClockIsOutput && bitClockOut;
               pinDrive.enable <= bitClockIsOutput;
            end
            codec_pin_pkg::FN_HEADSET, codec_pin_pkg::FN_HS_BTN,
            codec_pin_pkg::FN_ALL_FOUR, codec_pin_pkg::FN_SC_BTN,
            codec_pin_pkg::FN_HS_BTN_SC, codec_pin_pkg::FN_SC_A,
            codec_pin_pkg::FN_SC_B, codec_pin_pkg::FN_BUTTON: begin
               pinDrive.level  <= pulseLevel;
               pinDrive.enable <= 1'b1;
            end
         endcase
      end
   end

   // Open drain: level is always low, enable pulls the line down.
   // Outside SPI mode the lines belong to the control bus.
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sdaDrive <= '0;
         sclDrive <= '0;
      end else begin
         sdaDrive.level  <= 1'b0;
         sdaDrive.enable <= spiMode &&
            (dataMode == codec_pin_pkg::LINE_OUTPUT) &&
            !controlPins[codec_pin_pkg::BIT_DATA_OUT];
         sclDrive.level  <= 1'b0;
         sclDrive.enable <= spiMode &&
            (clockMode == codec_pin_pkg::LINE_OUTPUT) &&
            !controlPins[codec_pin_pkg::BIT_CLK_OUT];
      end
   end

endmodule
`default_nettype wire

/* File: verilog/codec_pin_pkg.sv */
`default_nettype none
package codec_pin_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0]  IDX_PIN_FUNCTION = 8'h63;
   localparam logic [7:0]  IDX_CONTROL_PINS = 8'h64;
   localparam logic [31:0] ADDR_PIN_FUNCTION = {22'h0, IDX_PIN_FUNCTION, 2'h0};
   localparam logic [31:0] ADDR_CONTROL_PINS = {22'h0, IDX_CONTROL_PINS, 2'h0};
   localparam logic [7:0]  RESET_PIN_FUNCTION = 8'h00;
   localparam logic [7:0]  RESET_CONTROL_PINS = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int FUNC_HI     = 7;
   localparam int FUNC_LO     = 4;
   localparam int BIT_OUT_VAL = 3;
   localparam int BIT_IN_VAL  = 2;
   localparam int BIT_REPEAT  = 1;
   localparam int DATA_MODE_HI = 7;
   localparam int DATA_MODE_LO = 6;
   localparam int BIT_DATA_OUT = 5;
   localparam int BIT_DATA_IN  = 4;
   localparam int CLK_MODE_HI  = 3;
   localparam int CLK_MODE_LO  = 2;
   localparam int BIT_CLK_OUT  = 1;
   localparam int BIT_CLK_IN   = 0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 50;
   localparam int PULSE_TIME_NS   = 2000000;
   localparam int HEADSET_TIME_NS = 1750000;
   localparam int PULSE_CYCLES    = PULSE_TIME_NS / CLK_PERIOD_NS;
   localparam int HEADSET_CYCLES  = HEADSET_TIME_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      FN_DISABLED  = 4'h0, FN_RESERVED  = 4'h1, FN_HEADSET   = 4'h2,
      FN_GP_INPUT  = 4'h3, FN_GP_OUTPUT = 4'h4, FN_MIC_A     = 4'h5,
      FN_MIC_B     = 4'h6, FN_MIC_C     = 4'h7, FN_BIT_CLOCK = 4'h8,
      FN_HS_BTN    = 4'h9, FN_ALL_FOUR  = 4'ha, FN_SC_BTN    = 4'hb,
      FN_HS_BTN_SC = 4'hc, FN_SC_A      = 4'hd, FN_SC_B      = 4'he,
      FN_BUTTON    = 4'hf
   } function_type;

   typedef enum logic [1:0] {
      LINE_NOT_GPIO = 2'h0, LINE_INPUT = 2'h1, LINE_OUTPUT = 2'h2,
      LINE_RESERVED = 2'h3
   } line_mode_type;

   typedef struct packed {
      logic headset;
      logic button;
      logic shortCircuit;
      logic gainNoise;
   } irq_source_type;

   typedef struct packed {
      logic level;
      logic enable;
   } pin_drive_type;

   typedef enum logic [1:0] {
      PULSE_IDLE = 2'h0, PULSE_HIGH = 2'h1, PULSE_GAP = 2'h2
   } pulse_state_type;

endpackage
`default_nettype wire

/* File: dv/codec_pin_function_mux_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module codec_pin_function_mux_chk #(
   parameter int PULSE_LEN   = 8,
   parameter int HEADSET_LEN = 5
) (
   input wire logic                         clk_sys,
   input wire logic                         rst,
   input wire logic                         hsel,
   input wire logic [31:0]                  haddr,
   input wire logic [1:0]                   htrans,
   input wire logic                         hwrite,
   input wire logic [31:0]                  hwdata,
   input wire logic                         hready,
   input wire logic                         bitClockIsOutput,
   input wire logic                         bitClockOut,
   input wire logic                         selectSpi,
   input wire codec_pin_pkg::pin_drive_type pinDrive,
   input wire codec_pin_pkg::pin_drive_type sdaDrive,
   input wire codec_pin_pkg::pin_drive_type sclDrive
);
   // ---------------------------------------------
   // Shadow of the two registers, from bus writes
   // ---------------------------------------------
   logic        wrPend;
   logic [31:0] wrAddr;
   logic [7:0]  fnReg;
   logic [7:0]  ctlReg;
   int          hiCnt;
   logic        irqRole;
   logic        quietRole;
   assign irqRole   = fnReg[7:4] == 4'h2 || fnReg[7:4] > 4'h8;
   assign quietRole = fnReg[7:4] inside {4'h0, 4'h3, 4'h5, 4'h6, 4'h7};
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wrPend <= 1'b0;
         wrAddr <= 32'h00000000;
      end else if (hready) begin
         wrPend <= hsel && hwrite && htrans == 2'h2;
         wrAddr <= haddr;
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fnReg  <= 8'h00;
         ctlReg <= 8'h00;
      end else if (wrPend && hready) begin
         if (wrAddr == codec_pin_pkg::ADDR_PIN_FUNCTION) fnReg <= hwdata[7:0];
         if (wrAddr == codec_pin_pkg::ADDR_CONTROL_PINS) ctlReg <= hwdata[7:0];
      end
   end
   // Length of the current high stretch on the pin
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) hiCnt <= 0;
      else hiCnt <= pinDrive.level ? hiCnt + 1 : 0;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   pin_quiet_a: assert property (quietRole |=> !pinDrive.enable)
      else $error("pin driven in a non-output role");
   pin_output_a: assert property (fnReg[7:4] == 4'h4 |=>
      pinDrive.enable && pinDrive.level == $past(fnReg[3]))
      else $error("general output level wrong");
   irq_width_a: assert property ($fell(pinDrive.level) && irqRole
      && $past(irqRole, 2) |-> hiCnt == (fnReg[7:4] == 4'h2 ?
      HEADSET_LEN : PULSE_LEN)) else $error("interrupt pulse width wrong");
   bit_clock_a: assert property (fnReg[7:4] == 4'h8 && bitClockIsOutput
      && $stable(bitClockIsOutput) && $stable(bitClockOut) |=>
      pinDrive.enable && pinDrive.level == $past(bitClockOut))
      else $error("bit clock not driven out");
   open_drain_a: assert property (sdaDrive.enable || sclDrive.enable
      |-> !sdaDrive.level && !sclDrive.level)
      else $error("control line driven high");
   sda_low_a: assert property (selectSpi [*4] ##0 ctlReg[7:6] == 2'h2
      && !ctlReg[5] |=> sdaDrive.enable) else $error("data line not pulled");
   sda_off_a: assert property (ctlReg[7:6] != 2'h2 || ctlReg[5]
      |=> !sdaDrive.enable) else $error("data line pulled when not asked");
   scl_off_a: assert property (ctlReg[3:2] != 2'h2 || ctlReg[1]
      |=> !sclDrive.enable) else $error("clock line pulled when not asked");
   strap_off_a: assert property (!selectSpi [*4] |=>
      !sdaDrive.enable && !sclDrive.enable)
      else $error("control lines used without the strap");
endmodule
bind codec_pin_function_mux codec_pin_function_mux_chk #(
   .PULSE_LEN(PULSE_LEN), .HEADSET_LEN(HEADSET_LEN)) u_chk (.*);
`default_nettype wire

/* File: dv/pin_side_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pin_side_model (
   input wire codec_pin_pkg::pin_drive_type pinDrive,
   input wire codec_pin_pkg::pin_drive_type sdaDrive,
   input wire codec_pin_pkg::pin_drive_type sclDrive,
   input wire logic                         extPin,
   input wire logic                         extLow,
   output logic                             pinIn,
   output logic                             sdaIn,
   output logic                             sclIn
);
   // Outside logic only drives the pin while the device lets go
   assign pinIn = pinDrive.enable ? pinDrive.level : extPin;
   // Pull-ups: a driven high never reaches the wire, only a pull low
   assign sdaIn = !(extLow || sdaDrive.enable);
   assign sclIn = !(extLow || sclDrive.enable);
endmodule
`default_nettype wire

/* File: dv/codec_pin_function_mux_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module codec_pin_function_mux_tb;
   localparam int PL = 8;
   localparam int HL = 5;
   localparam logic [31:0] AF = codec_pin_pkg::ADDR_PIN_FUNCTION;
   localparam logic [31:0] AC = codec_pin_pkg::ADDR_CONTROL_PINS;
   typedef struct packed {
      logic [31:0] addr;
      logic [7:0]  wr;
      logic        ext;
      logic [1:0]  sel;
      logic [1:0]  drv;
      logic [7:0]  rd;
   } row_type;
   typedef struct packed {
      logic [7:0] fn;
      logic [3:0] src;
      int         hi;
   } irq_row_type;
   logic        clk_sys, rst, hsel, hwrite, flagRead, micClock, extPin;
   logic        bitClockIsOutput, bitClockOut, selectSpi, extLow, hready;
   logic        hresp, micData, micDataValid, bitClockIn, pinIn, sdaIn, sclIn;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          n_mismatch, comparisons, n, hi, rises;
   codec_pin_pkg::irq_source_type irqSource;
   codec_pin_pkg::pin_drive_type  pinDrive, sdaDrive, sclDrive, drv;
   row_type rows[12] = '{
      '{AF, 8'h30, 1'b1, 2'h0, 2'h0, 8'h34},
      '{AF, 8'h48, 1'b0, 2'h0, 2'h3, 8'h4c},
      '{AF, 8'h4d, 1'b0, 2'h0, 2'h3, 8'h4c},
      '{AF, 8'h40, 1'b1, 2'h0, 2'h1, 8'h40},
      '{AF, 8'h50, 1'b1, 2'h0, 2'h0, 8'h54},
      '{AF, 8'h00, 1'b1, 2'h0, 2'h0, 8'h04},
      '{AC, 8'h80, 1'b0, 2'h1, 2'h1, 8'h81},
      '{AC, 8'ha0, 1'b0, 2'h1, 2'h0, 8'hb1},
      '{AC, 8'h44, 1'b1, 2'h1, 2'h0, 8'h44},
      '{AC, 8'h08, 1'b0, 2'h2, 2'h1, 8'h18},
      '{AC, 8'h0a, 1'b0, 2'h2, 2'h0, 8'h1b},
      '{32'h194, 8'hff, 1'b0, 2'h2, 2'h0, 8'h00}};
   irq_row_type irqs[10] = '{'{8'h20, 4'h8, HL}, '{8'h90, 4'h4, PL},
      '{8'ha0, 4'h1, PL}, '{8'hb0, 4'h2, PL}, '{8'hc0, 4'h2, PL},
      '{8'hc0, 4'h1, 0}, '{8'hd0, 4'h2, PL}, '{8'he0, 4'h2, PL},
      '{8'hf0, 4'h4, PL}, '{8'hf0, 4'h8, 0}};
   codec_pin_function_mux #(.PULSE_LEN(PL), .HEADSET_LEN(HL))
      u_codec_pin_function_mux (.hreadyout(hready), .*);
   pin_side_model u_pin_side_model (.*);
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish();
      if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Bounded single transfer
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [7:0] d, output logic [31:0] q);
      int k = 0;
      @(posedge clk_sys);
      {hsel, htrans, haddr, hwrite} <= {1'b1, 2'h2, a, wr};
      do @(posedge clk_sys); while (hready !== 1'b1 && ++k < 40);
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h000000, d};
      do @(posedge clk_sys); while (hready !== 1'b1 && ++k < 80);
      if (k >= 80) begin
         n_mismatch++;
         tally_and_finish();
      end else q = hrdata;
   endtask
   task automatic irq_count(input logic [7:0] fn, input logic [3:0] src);
      logic prev = 1'b0;
      {hi, rises} = {32'h0, 32'h0};
      bus(1'b1, AF, fn, rd);
      irqSource <= codec_pin_pkg::irq_source_type'(src);
      repeat (40) begin
         @(posedge clk_sys);
         #1;
         hi += int'(pinDrive.level === 1'b1);
         rises += int'(pinDrive.level === 1'b1 && !prev);
         prev = pinDrive.level;
      end
      irqSource <= 4'h0;
   endtask
   task automatic reset_and_check();
      rst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      bus(1'b0, AF, 8'h00, rd);
      check("fn reset", 32'h0, rd);
      bus(1'b0, AC, 8'h00, rd);
      check("ctl reset", 32'h11, rd);
      check("hresp", 32'h0, {31'h0, hresp});
   endtask
   initial begin
      {rst, hsel, hwrite, flagRead, micClock, extPin, extLow} = 7'h40;
      {bitClockIsOutput, bitClockOut, selectSpi, irqSource} = 7'h10;
      {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
      {n_mismatch, comparisons} = {32'h0, 32'h0};
      reset_and_check();
      foreach (rows[i]) begin
         {extPin, extLow} <= {2{rows[i].ext}};
         bus(1'b1, rows[i].addr, rows[i].wr, rd);
         repeat (4) @(posedge clk_sys);
         bus(1'b0, rows[i].addr, 8'h00, rd);
         check("readback", {24'h0, rows[i].rd}, rd);
         drv = rows[i].sel == 2'h0 ? pinDrive :
               rows[i].sel == 2'h1 ? sdaDrive : sclDrive;
         check("drive", {30'h0, rows[i].drv}, {30'h0, drv});
      end
      foreach (irqs[i]) begin
         irq_count(irqs[i].fn, irqs[i].src);
         check("pulse cycles", irqs[i].hi, hi);
      end
      // Repeats stop on flag read
      irq_count(8'h92, 4'h4);
      check("repeats", 32'h1, {31'h0, rises > 1});
      flagRead <= 1'b1;
      @(posedge clk_sys);
      flagRead <= 1'b0;
      repeat (2 * PL + 4) @(posedge clk_sys);
      irq_count(8'h92, 4'h0);
      check("after flag read", 32'h0, hi);
      extPin <= 1'b1;
      bus(1'b1, AF, 8'h60, rd);
      n = 0;
      for (int k = 0; k < 32; k++) begin
         @(posedge clk_sys);
         if (k % 4 == 0 && k < 16) micClock <= ~micClock;
         #1;
         n += int'(micDataValid === 1'b1);
      end
      check("mic samples", 32'h4, n);
      check("mic data", 32'h1, {31'h0, micData});
      {bitClockIsOutput, bitClockOut} <= 2'h3;
      bus(1'b1, AF, 8'h80, rd);
      repeat (3) @(posedge clk_sys);
      check("bit clock out", 32'h3, {30'h0, pinDrive});
      bitClockIsOutput <= 1'b0;
      repeat (5) @(posedge clk_sys);
      check("clk in", 32'h1, {30'h0, pinDrive.enable, bitClockIn});
      selectSpi <= 1'b0;
      bus(1'b1, AC, 8'h80, rd);
      repeat (5) @(posedge clk_sys);
      check("strap low", 32'h0, {31'h0, sdaDrive.enable});
      selectSpi <= 1'b1;
      repeat (5) @(posedge clk_sys);
      check("strap high", 32'h1, {31'h0, sdaDrive.enable});
      {extPin, extLow} <= 2'h0;
      reset_and_check();
      tally_and_finish();
   end
endmodule
`default_nettype wire
